//--- ee_pkg.sv
// shared constants of the serial eeprom command port
package ee_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned PROG_TIME_MS    = 10;
  localparam int unsigned PROG_CYCLES     = PROG_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned BYTE_LOCS       = 256;
  localparam int unsigned WORD_LOCS       = 128;
  localparam int unsigned BYTE_BITS       = 8;
  localparam int unsigned WORD_BITS       = 16;
  localparam int unsigned BYTE_ADDR_BITS  = 9;
  localparam int unsigned WORD_ADDR_BITS  = 8;
  localparam int unsigned FIFO_WIDTH      = 16;
  localparam int unsigned FIFO_DEPTH      = 16;
  localparam logic [1:0]  OP_SPECIAL      = 2'h0;
  localparam logic [1:0]  OP_WRITE        = 2'h1;
  localparam logic [1:0]  OP_READ         = 2'h2;
  localparam logic [1:0]  OP_ERASE        = 2'h3;
  localparam logic [1:0]  SUB_LOCK        = 2'h0;
  localparam logic [1:0]  SUB_FILL        = 2'h1;
  localparam logic [1:0]  SUB_CLEAR       = 2'h2;
  localparam logic [1:0]  SUB_UNLOCK      = 2'h3;
  localparam logic [15:0] ERASED_WORD     = 16'hFFFF;
  localparam logic [4:0]  OP_BITS         = 5'h2;
endpackage

//--- ee_wr_if.sv
// write-request carrier between the decoder and the programming queue
`timescale 1ns/1ps
`default_nettype none
interface ee_wr_if;
  logic        valid;
  logic        ready;
  logic [15:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- ee_fifo.sv
// parameterised valid/ready fifo
`timescale 1ns/1ps
`default_nettype none
module ee_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wp_q, wp_d, rp_q, rp_d;
  logic             push, pop;
  assign in_ready  = (wp_q - rp_q) != (AW+1)'(DEPTH);
  assign out_valid = wp_q != rp_q;
  assign out_data  = mem_q[rp_q[AW-1:0]];
  assign push      = in_valid && in_ready && ce;
  assign pop       = out_valid && out_ready && ce;
  always_comb begin
    wp_d = wp_q + (AW+1)'(push);
    rp_d = rp_q + (AW+1)'(pop);
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= in_data;
    end
  end
endmodule
`default_nettype wire

//--- ee_sync.sv
// two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
`default_nettype none
module ee_sync #(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);
  logic [WIDTH-1:0] meta_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_q  <= '0;
      pin_out <= '0;
    end else begin
      meta_q  <= pin_in;
      pin_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

//--- ee_port.sv
// command decoder, sequencer and array of the serial eeprom
// Behaviour
// - width pin high gives 128 x 16 words, low gives 256 x 8 bytes.
// - reset clears programming logic and leaves programming locked.
// - instruction is 2-bit op-code then 8-bit (x16) or 9-bit (x8) address.
// - select rises with clock low; first one sampled on rising clock is start.
// - logic is static, works at any link clock up to 1 MHz.
// - read sends a zero bit then the data msb first.
// - read data on the output changes only after a rising link clock edge.
// - select held high streams next locations without the zero bit.
// - sequential read address wraps from top to zero.
// - unlock sets enable latch; lock or reset clears it.
// - reads execute whatever the latch state.
// - erase sets location to ones; starts at select fall after address.
// - write takes address then 8 or 16 data bits on rising clocks.
// - write erases itself first; timing internal, clock may stop.
// - busy drives output low with select high; ready drives high, but not if select rises after busy ends.
// - status stays on output until new start bit or select low.
// - programming cycle ends within 10 ms of start.
// - op-codes 10 read, 01 write, 11 erase, 00 special.
// - special: 11 unlock, 00 lock, 10 clear all, 01 fill all.
// - top address bit is ignored by read, write and erase.
// - bulk clear sets whole array to ones with busy/ready.
// - bulk fill writes data to every location with busy/ready.
`timescale 1ns/1ps
`default_nettype none
module ee_port
  import ee_pkg::*;
#(
  parameter int unsigned PROG_COUNT = PROG_CYCLES
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic ce,
  input  wire logic sel,
  input  wire logic sclk,
  input  wire logic din,
  input  wire logic org_word,
  output logic      dout,
  output logic      dout_oe,
  output logic      unlocked,
  output logic      busy
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01, ST_OP = 6'h02, ST_ADDR = 6'h04,
    ST_DATA = 6'h08, ST_READ = 6'h10, ST_WAIT = 6'h20
  } state_e;
  logic [3:0] pins;
  logic       sel_s, sclk_s, din_s, org_s;
  ee_sync #(.WIDTH(4)) u_sync (
    .clk     (clk),
    .nrst    (nrst),
    .pin_in  ({sel, sclk, din, org_word}),
    .pin_out (pins)
  );
  assign {sel_s, sclk_s, din_s, org_s} = pins;

  // array held as 128 words; x8 byte n is the high half of word n>>1 when n[0] is 0, the low half when 1
  logic [15:0] mem_q [WORD_LOCS];

  state_e      st_q, st_d;
  logic        sclk_q, sel_q;
  logic [1:0]  op_q, op_d;
  logic [8:0]  addr_q, addr_d;
  logic [15:0] sh_q, sh_d;
  logic [4:0]  cnt_q, cnt_d;
  logic        en_q, en_d, dout_d, oe_d;
  logic        cmd_ok_q, cmd_ok_d;
  logic        rise, fall_sel;
  logic        prog_start;
  logic [31:0] tmr_q, tmr_d;
  logic        busy_d;
  logic [8:0]  pa_q;
  logic [1:0]  pk_q;
  logic        porg_q;
  logic        prog_go;
  ee_wr_if     wr ();

  function automatic logic [4:0] addr_len(input logic word);
    addr_len = word ? 5'(WORD_ADDR_BITS) : 5'(BYTE_ADDR_BITS);
  endfunction
  function automatic logic [4:0] data_len(input logic word);
    data_len = word ? 5'(WORD_BITS) : 5'(BYTE_BITS);
  endfunction
  function automatic logic [15:0] rd_loc(input logic word, input logic [8:0] a,
                                         input logic [15:0] w);
    if (word) rd_loc = w;
    else      rd_loc = a[0] ? {w[7:0], 8'h00} : {w[15:8], 8'h00};
  endfunction

  assign rise     = sclk_s && !sclk_q;
  assign fall_sel = sel_q && !sel_s;

  logic [15:0] rd_word;
  logic [15:0] rd_val;
  logic [8:0]  nxt_a;
  always_comb begin
    // top address bit dropped when indexing
    rd_word = org_s ? mem_q[addr_q[6:0]] : mem_q[addr_q[7:1]];
    rd_val = rd_loc(org_s, addr_q, rd_word);
    nxt_a = org_s ? {2'b00, 7'(addr_q[6:0] + 7'h01)} : {1'b0, 8'(addr_q[7:0] + 8'h01)};
  end

  always_comb begin
    st_d = st_q; op_d = op_q; addr_d = addr_q; sh_d = sh_q; cnt_d = cnt_q;
    en_d = en_q; dout_d = dout; oe_d = dout_oe; cmd_ok_d = cmd_ok_q;
    prog_start = 1'b0;
    if (!sel_s) begin
      oe_d = 1'b0;
      dout_d = 1'b0;
      if (fall_sel && cmd_ok_q) prog_start = 1'b1;
      cmd_ok_d = 1'b0;
      st_d = ST_IDLE;
    end else if (busy) begin
      oe_d = 1'b1; // ignore input while busy
      dout_d = 1'b0;
      st_d = ST_IDLE;
    end else begin
      unique case (st_q)
        ST_IDLE, ST_WAIT: begin
          if (!busy) begin
            oe_d = sel_q && (st_q == ST_WAIT || dout_oe); // ready status
            dout_d = 1'b1;
          end
          if (rise && din_s) begin
            oe_d = 1'b0; dout_d = 1'b0;
            st_d = ST_OP; cnt_d = '0;
          end
        end
        ST_OP: if (rise) begin
          op_d = {op_q[0], din_s};
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == OP_BITS - 5'h01) begin st_d = ST_ADDR; cnt_d = '0; end
        end
        ST_ADDR: if (rise) begin
          addr_d = {addr_q[7:0], din_s};
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == addr_len(org_s) - 5'h01) begin
            cnt_d = '0;
            unique case (op_q)
              OP_READ: begin st_d = ST_READ; oe_d = 1'b1; dout_d = 1'b0; end
              OP_WRITE: st_d = ST_DATA;
              OP_ERASE: begin cmd_ok_d = en_q; st_d = ST_WAIT; end
              default: begin
                // two top address bits choose the special instruction
                unique case (org_s ? addr_d[7:6] : addr_d[8:7])
                  SUB_UNLOCK: begin en_d = 1'b1; st_d = ST_WAIT; end
                  SUB_LOCK:   begin en_d = 1'b0; st_d = ST_WAIT; end
                  SUB_CLEAR:  begin cmd_ok_d = en_q; st_d = ST_WAIT; end
                  SUB_FILL:   st_d = ST_DATA;
                endcase
              end
            endcase
          end
        end
        ST_DATA: if (rise) begin
          sh_d = {sh_q[14:0], din_s};
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == data_len(org_s) - 5'h01) begin
            cmd_ok_d = en_q; st_d = ST_WAIT;
          end
        end
        ST_READ: if (rise) begin
          // load on the first edge and at each location boundary
          if (cnt_q == 5'h00) begin
            sh_d = rd_val << 1;
            dout_d = rd_val[15];
            addr_d = nxt_a;
          end else begin
            dout_d = sh_q[15];
            sh_d = sh_q << 1;
          end
          cnt_d = (cnt_q == data_len(org_s) - 5'h01) ? 5'h00 : cnt_q + 5'h01;
        end
        default: st_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_IDLE; op_q <= '0; addr_q <= '0; sh_q <= '0; cnt_q <= '0;
      en_q <= 1'b0;
      dout <= 1'b0; dout_oe <= 1'b0; cmd_ok_q <= 1'b0;
      sclk_q <= 1'b0; sel_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d; op_q <= op_d; addr_q <= addr_d; sh_q <= sh_d; cnt_q <= cnt_d;
      en_q <= en_d; dout <= dout_d; dout_oe <= oe_d; cmd_ok_q <= cmd_ok_d;
      sclk_q <= sclk_s; sel_q <= sel_s;
    end
  end
  assign unlocked = en_q;

  // programming data goes through the queue; its kind and address are held in pk_q and pa_q
  assign wr.valid = prog_start;
  assign wr.data  = (op_q == OP_WRITE || (op_q == OP_SPECIAL
                    && (org_s ? addr_q[7:6] : addr_q[8:7]) == SUB_FILL))
                    ? (org_s ? sh_q : {sh_q[7:0], sh_q[7:0]}) : ERASED_WORD;
  logic        q_valid;
  logic [15:0] q_data;
  ee_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .ce        (ce),
    .in_valid  (wr.valid),
    .in_ready  (wr.ready),
    .in_data   (wr.data),
    .out_valid (q_valid),
    .out_ready (!busy),
    .out_data  (q_data)
  );
  assign prog_go = q_valid && !busy;

  logic [15:0] pdat_q;
  always_comb begin
    tmr_d = tmr_q; busy_d = busy;
    if (prog_go) begin busy_d = 1'b1; tmr_d = 32'(PROG_COUNT) - 32'h1; end
    else if (busy && tmr_q != 32'h0) tmr_d = tmr_q - 32'h1;
    else if (busy) busy_d = 1'b0;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tmr_q <= '0; busy <= 1'b0; pa_q <= '0; pk_q <= '0; porg_q <= 1'b0; pdat_q <= '0;
    end else if (ce) begin
      tmr_q <= tmr_d; busy <= busy_d;
      if (prog_start) begin
        pa_q <= addr_q; porg_q <= org_s;
        pk_q <= (op_q == OP_SPECIAL) ? 2'h1 : 2'h0;
      end
      if (prog_go) pdat_q <= q_data;
    end
  end

  // array update at end of cycle; write replaces the whole location
  always_ff @(posedge clk) begin
    if (ce && busy && !busy_d) begin
      for (int i = 0; i < WORD_LOCS; i++) begin
        if (pk_q[0]) mem_q[i] <= pdat_q;
        else if (porg_q && 7'(i) == pa_q[6:0]) mem_q[i] <= pdat_q;
        else if (!porg_q && 7'(i) == pa_q[7:1]) begin
          if (pa_q[0]) mem_q[i][7:0] <= pdat_q[7:0];
          else mem_q[i][15:8] <= pdat_q[7:0];
        end
      end
    end
  end

  // length of the running programming cycle, for the cycle-time check
  logic [31:0] busy_run_q, busy_run_d;
  always_comb begin
    busy_run_d = busy ? busy_run_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_run_q <= '0;
    end else if (ce) begin
      busy_run_q <= busy_run_d;
    end
  end

  unlock_lat_a: assert property (@(posedge clk) disable iff (!nrst)
    (ce && !en_q && cmd_ok_q) |-> 1'b0) else $error("programming armed while locked");
  busy_low_a: assert property (@(posedge clk) disable iff (!nrst)
    (busy && sel_s && ce) |=> (!dout || !busy)) else $error("busy not low");
  busy_len_a: assert property (@(posedge clk) disable iff (!nrst)
    (busy_run_q > 32'(PROG_COUNT)) |-> 1'b0) else $error("cycle too long");
  read_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_q == ST_ADDR && st_d == ST_READ && ce) |=> !dout) else $error("no zero bit");
  out_edge_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_q == ST_READ && sel_s && $changed(dout)) |-> $past(rise)) else $error("out moved");
  reset_lock_a: assert property (@(posedge clk) $rose(nrst) |-> !en_q)
    else $error("unlocked at reset");
  start_bit_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_q == ST_IDLE && st_d == ST_OP) |-> din_s) else $error("bad start");
  sel_drop_a: assert property (@(posedge clk) disable iff (!nrst)
    (!sel_s && ce) |=> !dout_oe) else $error("output held");
  read_c: cover property (@(posedge clk) st_q == ST_READ);
  prog_c: cover property (@(posedge clk) $fell(busy));
  unlock_c: cover property (@(posedge clk) $rose(en_q));
endmodule
`default_nettype wire

//--- ee_host.sv
// host-side model that drives the serial link of the eeprom port
`timescale 1ns/1ps
`default_nettype none
module ee_host (
  input  wire logic clk,
  input  wire logic dout,
  output logic      sel,
  output logic      sclk,
  output logic      din
);
  initial begin
    sel  = 1'b0;
    sclk = 1'b0;
    din  = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic select(input logic s);
    sel = s;
    hold(4);
  endtask

  // link clock half period of 40 ns is four system clocks; it stands low outside frames
  task automatic frame(input int n, input logic [63:0] v, output logic [63:0] rx);
    rx = '0;
    hold(1);
    sel = 1'b1; // select rises while the link clock is low
    for (int i = n - 1; i >= 0; i--) begin
      din = v[i];
      hold(4);
      if (i < n - 1) rx = {rx[62:0], dout};
      sclk = 1'b1;
      hold(4);
      sclk = 1'b0;
    end
    hold(4);
    rx = {rx[62:0], dout};
    sel = 1'b0; // select drops before any further rising link clock edge
    din = ~din;
    hold(4);
  endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// self-checking bench of the serial eeprom command port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ee_pkg::*;
  localparam int unsigned PC = 50;
  logic        clk;
  logic        nrst;
  logic        sel;
  logic        sclk;
  logic        din;
  logic        org_word;
  logic        dout;
  logic        dout_oe;
  logic        unlocked;
  logic        busy;
  logic [63:0] rx;
  int          failures = 0;
  int          tests_run = 0;
  int          cyc = 0;

  ee_port #(.PROG_COUNT(PC)) u_dut (
    .clk(clk), .nrst(nrst), .ce(1'b1), .sel(sel), .sclk(sclk), .din(din),
    .org_word(org_word), .dout(dout), .dout_oe(dout_oe), .unlocked(unlocked), .busy(busy)
  );
  ee_host u_host (.clk(clk), .dout(dout), .sel(sel), .sclk(sclk), .din(din));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic close_out();
    if (failures == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      close_out();
    end
  end

  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic int abits();
    return org_word ? 8 : 9;
  endfunction

  function automatic int dbits();
    return org_word ? 16 : 8;
  endfunction

  // frame of start, op-code, address and optional data; go says a programming cycle is due
  task automatic prog(input logic [1:0] op, input logic [8:0] a, input logic [15:0] d,
                      input logic hasd, input logic go);
    logic [63:0] v;
    int          n;
    int          t;
    v = {61'h0, 1'b1, op};
    v = (v << abits()) | (64'(a) & ((64'h1 << abits()) - 1));
    n = 3 + abits();
    if (hasd) begin
      v = (v << dbits()) | (64'(d) & ((64'h1 << dbits()) - 1));
      n += dbits();
    end
    u_host.frame(n, v, rx);
    hold(6);
    chk(busy, go);
    if (go) begin
      u_host.select(1'b1);
      hold(6);
      chk(dout, 1'b0);
      t = 0;
      while (busy === 1'b1 && t < 2000) begin
        hold(1);
        t++;
      end
      chk(t <= PC, 1'b1);
      hold(6);
      chk(dout, 1'b1);
      hold(20);
      chk({dout_oe, dout}, 2'h3);
      u_host.select(1'b0);
    end
  endtask

  task automatic spec(input logic [1:0] sub, input logic [15:0] d, input logic go);
    prog(OP_SPECIAL, 9'(sub) << (abits() - 2), d, sub == SUB_FILL, go);
  endtask

  // read k units; the leading zero comes once, before the first unit only
  task automatic rd(input logic [8:0] a, input int k, input logic [31:0] exp);
    logic [63:0] v;
    int          m;
    m = dbits() * k;
    v = {61'h0, 1'b1, OP_READ};
    v = (v << abits()) | (64'(a) & ((64'h1 << abits()) - 1));
    u_host.frame(3 + abits() + m, v << m, rx);
    chk(rx[m], 1'b0);
    chk(32'(rx & ((64'h1 << m) - 1)), exp);
  endtask

  initial begin
    logic [8:0]  a;
    logic [15:0] d;
    logic [15:0] d2;
    nrst = 1'b0;
    org_word = 1'b1;
    void'($urandom(32'h07C2));
    hold(8);
    chk({busy, unlocked, dout_oe}, 3'h0);
    nrst = 1'b1;
    hold(6);
    chk({busy, unlocked}, 2'h0);
    prog(OP_WRITE, 9'h003, 16'h1234, 1'b1, 1'b0);
    spec(SUB_UNLOCK, 16'h0, 1'b0);
    chk(unlocked, 1'b1);
    spec(SUB_CLEAR, 16'h0, 1'b1);
    rd(9'($urandom_range(127)), 1, 32'h0000FFFF);
    repeat (4) begin
      a = 9'($urandom_range(126));
      d = 16'($urandom);
      prog(OP_WRITE, a, d, 1'b1, 1'b1);
      rd(a | 9'h080, 1, {16'h0, d});
    end
    d = 16'($urandom);
    d2 = 16'($urandom);
    prog(OP_WRITE, 9'h07F, d, 1'b1, 1'b1);
    prog(OP_WRITE, 9'h000, d2, 1'b1, 1'b1);
    rd(9'h07F, 2, {d, d2});
    prog(OP_ERASE, 9'h000, 16'h0, 1'b0, 1'b1);
    rd(9'h000, 1, 32'h0000FFFF);
    org_word = 1'b0;
    hold(4);
    spec(SUB_FILL, d, 1'b1);
    prog(OP_WRITE, 9'h141, d2, 1'b1, 1'b1);
    rd(9'h040, 2, {16'h0, d[7:0], d2[7:0]});
    org_word = 1'b1;
    hold(4);
    rd(9'h030, 1, {16'h0, d[7:0], d[7:0]});
    spec(SUB_LOCK, 16'h0, 1'b0); // lock after programming
    chk(unlocked, 1'b0);
    prog(OP_ERASE, 9'h030, 16'h0, 1'b0, 1'b0);
    rd(9'h030, 1, {16'h0, d[7:0], d[7:0]});
    close_out();
  end
endmodule
`default_nettype wire
